// file: ssr_pkg.sv
/*
 * Shared constants and types for the setup settle/repeat block.
 * Assumes an AXI4-Lite master with 32-bit data and a converter that
 * runs on the same clock as the register bus.
 */
package ssr_pkg;

	// ----------------------------------------------------------------
	// Register map (indices, byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int         ADDR_W         = 10;        // Byte address width
	localparam logic [7:0] CTRL_IDX       = 8'h01;     // Sequencer control
	localparam logic [7:0] FILT_IDX_FIRST = 8'h21;     // Setup 0 filter config
	localparam logic [7:0] FILT_IDX_LAST  = 8'h28;     // Setup 7 filter config
	localparam logic [7:0] CHAN_IDX       = 8'h09;     // Channel enables/setups
	localparam logic [7:0] STAT_IDX       = 8'h0a;     // Sequencer status

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam logic [23:0] FILT_RST      = 24'h002030; // Filter config reset
	localparam logic [23:0] FILT_MASK     = 24'hfff7ff; // Bit 11 reserved
	localparam int          CTRL_RUN      = 0;          // Sequencer enable
	localparam int          CTRL_DUTY     = 1;          // Duty-cycled operation
	localparam int          CTRL_CAL      = 2;          // Any calibration mode
	localparam int          NUM_SETUP     = 8;          // Setups
	localparam int          NUM_CH        = 4;          // Sequenced channels
	localparam int          CHAN_FLD_W    = 4;          // Per-channel field width
	localparam int          CHAN_EN_BIT   = 3;          // Enable inside field
	localparam int          SETTLE_MCLK   = 32;         // Wait for code 000
	localparam logic [1:0]  RESP_OKAY     = 2'h0;       // AXI OKAY
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;       // AXI SLVERR

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  front_end_wait_sel; // Settling code
		logic [4:0]  repeat_cnt;         // Extra conversions per channel
		logic [3:0]  filter_type;        // Digital filter select
		logic        rsvd;               // Reads zero
		logic [10:0] output_rate_sel;    // Output rate code
	} ssr_filt_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} ssr_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ssr_axil_rsp_t;

	typedef enum logic [1:0] {SQ_IDLE, SQ_SETTLE, SQ_START, SQ_CONV} ssr_state_t;

endpackage : ssr_pkg

// file: ssr_top.sv
/*
 * Per-setup filter configuration and channel sequencer timing.
 * Assumes conv_done comes from converter logic on clk_sys, and that
 * clk_sys is the master clock in which settling is counted.
 */
`timescale 1ns/1ps

// Function
// RULE1: Eight filter registers, 0x21-0x28, reset 0x002030
// RULE2: Channel uses setup its selection field names
// RULE3: Settle code gives 32 doubling to 4096
// RULE4: Hold off settling before starting conversion
// RULE5: Settle on every change to different channel
// RULE6: No settle between repeated same-channel conversions
// RULE7: Repeat field N converts N+1 times
// RULE8: Repeat zero means exactly one conversion
// RULE9: Repeat ignored in duty-cycle or calibration
// RULE10: Filter type field, reset 0x2, 0000 sinc4
// RULE11: Output rate field, reset 0x30, zero as one
// RULE12: Settle counter restarts, releases after full count
module ssr_top
	import ssr_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// Register bus
	input  wire ssr_pkg::ssr_axil_req_t axi_req,
	output ssr_pkg::ssr_axil_rsp_t      axi_rsp,
	// Converter handshake
	input  wire logic                  conv_done,
	output logic                       conv_start,
	output logic                       settling,
	// Active configuration
	output logic [1:0]                 conv_channel,
	output logic [2:0]                 conv_setup,
	output logic [3:0]                 conv_filter_type,
	output logic [10:0]                conv_rate
);
	import ssr_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Filter register index test, used by read and write decode
	function automatic logic is_filt(input logic [7:0] idx);
		return (idx >= FILT_IDX_FIRST) && (idx <= FILT_IDX_LAST);
	endfunction : is_filt

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// Settling length minus one, for the down counter
	function automatic logic [11:0] settle_load(input logic [2:0] code);
		logic [12:0] len;
		len = 13'(SETTLE_MCLK) << code;
		return 12'(len - 13'h1);
	endfunction : settle_load

	// Next enabled channel after cur, wrapping; cur itself if alone
	function automatic logic [1:0] next_ch(input logic [1:0] cur, input logic [15:0] chan);
		logic [1:0] res;
		logic [1:0] c;
		logic       found;
		res = cur;
		found = 1'b0;
		for (int i = 1; i <= NUM_CH; i++) begin
			c = 2'(cur + 2'(i));
			if (!found && chan[c*CHAN_FLD_W + CHAN_EN_BIT]) begin
				res = c;
				found = 1'b1;
			end
		end
		return res;
	endfunction : next_ch

	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	logic              aw_full, next_aw_full;    // Address held
	logic [7:0]        aw_idx, next_aw_idx;      // Held write index
	logic              w_full, next_w_full;      // Data held
	logic [31:0]       w_data, next_w_data;      // Held write data
	logic [3:0]        w_strb, next_w_strb;      // Held byte enables
	logic              bvalid, next_bvalid;      // Write answer pending
	logic [1:0]        bresp, next_bresp;        // Write answer code
	logic              rvalid, next_rvalid;      // Read answer pending
	logic [31:0]       rdata, next_rdata;        // Read answer data
	logic [1:0]        rresp, next_rresp;        // Read answer code
	logic              reg_wr;                   // Write commits this cycle
	logic [7:0]        ar_idx;                   // Read index

	// ----------------------------------------------------------------
	// Register and sequencer state
	// ----------------------------------------------------------------
	ssr_filt_t         filt [NUM_SETUP];         // Setup filter configs
	ssr_filt_t         next_filt [NUM_SETUP];
	logic [2:0]        ctrl, next_ctrl;          // Run, duty, calibration
	logic [15:0]       chan, next_chan;          // Channel enable and setup
	ssr_state_t        state, next_state;        // Sequencer state
	logic [11:0]       cnt, next_cnt;            // Settling down counter
	logic [4:0]        rep, next_rep;            // Conversions done minus one
	logic [1:0]        ch, next_ch_q;            // Current channel
	logic [2:0]        setup, next_setup;        // Latched setup of channel
	ssr_filt_t         cur;                      // Config of current setup
	logic [4:0]        rep_lim;                  // Effective repeat limit
	logic [1:0]        nc;                       // Candidate next channel
	logic [3:0]        next_type;                // Output filter type
	logic [10:0]       next_rate;                // Output rate

	// Ready outputs are combinational, valid and data from flip-flops
	assign axi_rsp.awready = !aw_full;
	assign axi_rsp.wready  = !w_full;
	assign axi_rsp.arready = !rvalid;
	assign axi_rsp.bvalid  = bvalid;
	assign axi_rsp.bresp   = bresp;
	assign axi_rsp.rvalid  = rvalid;
	assign axi_rsp.rdata   = rdata;
	assign axi_rsp.rresp   = rresp;
	assign reg_wr          = aw_full && w_full && !bvalid;
	assign ar_idx          = axi_req.araddr[ADDR_W-1:2];
	assign conv_start      = (state == SQ_START);
	assign settling        = (state == SQ_SETTLE);
	assign conv_channel    = ch;
	assign conv_setup      = setup;

	// ----------------------------------------------------------------
	// Bus channel next-state
	// ----------------------------------------------------------------
	// Address and data are held separately so either may come first
	always_comb begin
		next_aw_full = aw_full;
		next_aw_idx  = aw_idx;
		next_w_full  = w_full;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		// Capture write address
		if (axi_req.awvalid && !aw_full) begin
			next_aw_full = 1'b1;
			next_aw_idx  = axi_req.awaddr[ADDR_W-1:2];
		end
		// Capture write data
		if (axi_req.wvalid && !w_full) begin
			next_w_full = 1'b1;
			next_w_data = axi_req.wdata;
			next_w_strb = axi_req.wstrb;
		end
		// Commit and answer; holds free only once answer is taken
		if (reg_wr) begin
			next_bvalid = 1'b1;
			next_bresp  = (is_filt(aw_idx) || aw_idx == CTRL_IDX || aw_idx == CHAN_IDX)
				? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && axi_req.bready) begin
			next_bvalid  = 1'b0;
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
		end
		// Read answer; unmapped reads give zero and an error code
		if (axi_req.arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			if (is_filt(ar_idx)) begin
				next_rdata = {8'h00, filt[3'(ar_idx - FILT_IDX_FIRST)]}; // RULE1
			end else if (ar_idx == CTRL_IDX) begin
				next_rdata = {29'h0, ctrl};
			end else if (ar_idx == CHAN_IDX) begin
				next_rdata = {16'h0, chan};
			end else if (ar_idx == STAT_IDX) begin
				next_rdata = {23'h0, rep, ch, state};
			end else begin
				next_rdata = 32'h0;
				next_rresp = RESP_SLVERR;
			end
		end else if (rvalid && axi_req.rready) begin
			next_rvalid = 1'b0;
		end
	end

	// Bus channel registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aw_full <= 1'b0;
			aw_idx  <= 8'h00;
			w_full  <= 1'b0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			aw_idx  <= next_aw_idx;
			w_full  <= next_w_full;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// Register file next-state
	// ----------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_chan = chan;
		for (int s = 0; s < NUM_SETUP; s++) begin
			next_filt[s] = filt[s];
		end
		if (reg_wr && is_filt(aw_idx)) begin
			// Reserved bit is masked so it always reads zero
			next_filt[3'(aw_idx - FILT_IDX_FIRST)] =
				24'(merge({8'h00, filt[3'(aw_idx - FILT_IDX_FIRST)]}, w_data, w_strb)
				& {8'h00, FILT_MASK}); // RULE1
		end else if (reg_wr && aw_idx == CTRL_IDX) begin
			next_ctrl = 3'(merge({29'h0, ctrl}, w_data, w_strb));
		end else if (reg_wr && aw_idx == CHAN_IDX) begin
			next_chan = 16'(merge({16'h0, chan}, w_data, w_strb));
		end
	end

	// Register file flip-flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl <= 3'h0;
			chan <= 16'h0;
			for (int s = 0; s < NUM_SETUP; s++) begin
				filt[s] <= FILT_RST; // RULE1 RULE3 RULE7 RULE10 RULE11
			end
		end else begin
			ctrl <= next_ctrl;
			chan <= next_chan;
			for (int s = 0; s < NUM_SETUP; s++) begin
				filt[s] <= next_filt[s];
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer next-state
	// ----------------------------------------------------------------
	assign cur     = filt[setup];
	// Duty cycling and calibration force one conversion per channel
	assign rep_lim = (ctrl[CTRL_DUTY] || ctrl[CTRL_CAL]) ? 5'h0 : cur.repeat_cnt; // RULE9
	assign nc      = next_ch(ch, chan);

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_rep   = rep;
		next_ch_q  = ch;
		next_setup = setup;
		// Configuration follows the setup named by the channel field
		next_type  = cur.filter_type; // RULE10
		next_rate  = (cur.output_rate_sel == 11'h0) ? 11'h1 : cur.output_rate_sel; // RULE11
		case (state)
			SQ_IDLE: begin
				// Starting counts as a channel change, so settle first
				if (ctrl[CTRL_RUN] && nc != ch || ctrl[CTRL_RUN] && chan[ch*CHAN_FLD_W + CHAN_EN_BIT]) begin
					next_ch_q  = chan[ch*CHAN_FLD_W + CHAN_EN_BIT] ? ch : nc;
					next_setup = chan[next_ch_q*CHAN_FLD_W +: 3]; // RULE2
					next_cnt   = settle_load(filt[next_setup].front_end_wait_sel); // RULE3 RULE12
					next_rep   = 5'h0;
					next_state = SQ_SETTLE;
				end
			end
			SQ_SETTLE: begin
				// Conversion start is held off until the count expires
				if (!ctrl[CTRL_RUN]) begin
					next_state = SQ_IDLE;
				end else if (cnt == 12'h0) begin
					next_state = SQ_START; // RULE4 RULE12
				end else begin
					next_cnt = cnt - 12'h1;
				end
			end
			SQ_START: begin
				next_state = SQ_CONV;
			end
			SQ_CONV: begin
				if (conv_done) begin
					if (rep < rep_lim) begin
						// Repeats go straight back to start with no wait
						next_rep   = rep + 5'h1; // RULE6 RULE7
						next_state = SQ_START;
					end else if (!ctrl[CTRL_RUN]) begin
						// Stopping leaves no repeat count behind
						next_rep   = 5'h0; // RULE7
						next_state = SQ_IDLE;
					end else if (nc != ch) begin
						// New channel: restart the settle count
						next_ch_q  = nc;
						next_setup = chan[nc*CHAN_FLD_W +: 3]; // RULE2
						next_cnt   = settle_load(filt[next_setup].front_end_wait_sel); // RULE5
						next_rep   = 5'h0;
						next_state = SQ_SETTLE;
					end else begin
						// No other channel enabled: no channel change
						next_rep   = 5'h0; // RULE8
						next_state = SQ_START;
					end
				end
			end
			default: begin
				next_state = SQ_IDLE;
			end
		endcase
		// Repeat count is not in use while duty cycling or calibrating,
		// so a count left from before the mode change is dropped at once
		if (ctrl[CTRL_DUTY] || ctrl[CTRL_CAL]) begin
			next_rep = 5'h0; // RULE9
		end
	end

	// Sequencer flip-flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state            <= SQ_IDLE;
			cnt              <= 12'h0;
			rep              <= 5'h0;
			ch               <= 2'h0;
			setup            <= 3'h0;
			conv_filter_type <= 4'h0;
			conv_rate        <= 11'h0;
		end else begin
			state            <= next_state;
			cnt              <= next_cnt;
			rep              <= next_rep;
			ch               <= next_ch_q;
			setup            <= next_setup;
			conv_filter_type <= next_type;
			conv_rate        <= next_rate;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Helper: cycles spent in the current settle period
	logic [12:0] settle_len;
	logic [12:0] settle_exp;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			settle_len <= 13'h0;
		end else begin
			settle_len <= settling ? settle_len + 13'h1 : 13'h0;
		end
	end
	assign settle_exp = 13'(SETTLE_MCLK) << filt[setup].front_end_wait_sel;

	property p_filt_read;
		@(posedge clk_sys) disable iff (!rstn)
		axi_req.arvalid && !rvalid && is_filt(ar_idx) |=> rresp == RESP_OKAY && rdata[31:24] == 8'h00;
	endproperty
	a_filt_read: assert property (p_filt_read) else $error("filter read bad"); // RULE1

	property p_setup_sel;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(settling) && $stable(chan) |-> setup == chan[ch*CHAN_FLD_W +: 3];
	endproperty
	a_setup_sel: assert property (p_setup_sel) else $error("wrong setup chosen"); // RULE2

	property p_settle_len;
		@(posedge clk_sys) disable iff (!rstn)
		settling && !$past(reg_wr) ##1 conv_start |-> $past(settle_len) + 13'h1 == settle_exp;
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("settle length wrong"); // RULE3 RULE12

	property p_start_src;
		@(posedge clk_sys) disable iff (!rstn)
		conv_start |-> $past(state) == SQ_SETTLE || $past(state) == SQ_CONV;
	endproperty
	a_start_src: assert property (p_start_src) else $error("start without settle"); // RULE4

	property p_change_settles;
		@(posedge clk_sys) disable iff (!rstn)
		state == SQ_CONV ##1 state != SQ_CONV && ch != $past(ch) |-> settling;
	endproperty
	a_change_settles: assert property (p_change_settles) else $error("no settle"); // RULE5

	property p_repeat_direct;
		@(posedge clk_sys) disable iff (!rstn)
		state == SQ_CONV && conv_done && rep < rep_lim |=> conv_start && $stable(ch);
	endproperty
	a_repeat_direct: assert property (p_repeat_direct) else $error("repeat waited"); // RULE6

	property p_repeat_end;
		@(posedge clk_sys) disable iff (!rstn)
		state == SQ_CONV && conv_done && rep == rep_lim |=> rep == 5'h0;
	endproperty
	a_repeat_end: assert property (p_repeat_end) else $error("repeat overran"); // RULE7 RULE8

	property p_duty_norep;
		@(posedge clk_sys) disable iff (!rstn)
		(ctrl[CTRL_DUTY] || ctrl[CTRL_CAL]) && !$past(reg_wr) |-> rep == 5'h0;
	endproperty
	a_duty_norep: assert property (p_duty_norep) else $error("repeat in duty"); // RULE9

	property p_type_out;
		@(posedge clk_sys) disable iff (!rstn)
		conv_start && !$past(reg_wr) |-> conv_filter_type == filt[setup].filter_type
			&& conv_rate != 11'h0;
	endproperty
	a_type_out: assert property (p_type_out) else $error("config out wrong"); // RULE10 RULE11

	c_settle_done: cover property (@(posedge clk_sys) disable iff (!rstn) settling ##1 conv_start);
	c_repeat: cover property (@(posedge clk_sys) disable iff (!rstn) rep == 5'h2);
	c_chan_change: cover property (@(posedge clk_sys) disable iff (!rstn)
		state == SQ_CONV ##1 settling);

endmodule : ssr_top

// file: ssr_tb.sv
/*
 * Self-checking bench for the setup settle/repeat block: register map,
 * settle lengths, repeat counts and duty/calibration handling.
 * Assumes ssr_pkg and ssr_top are compiled first; assertions live in the design.
 */
`timescale 1ns/1ps

module testbench;
	import ssr_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic          clk_sys;    // 100 MHz system clock
	logic          rstn;       // Active-low reset
	ssr_axil_req_t req;        // Bus master outputs
	ssr_axil_rsp_t rsp;        // Bus slave answers
	logic          conv_done;  // Converter end pulse
	logic          conv_start; // Conversion start pulse
	logic          settling;   // Settle in progress
	logic [1:0]    conv_channel;
	logic [2:0]    conv_setup;
	logic [3:0]    conv_filter_type;
	logic [10:0]   conv_rate;
	int            n_mismatch; // Mismatch count
	int            tests_run;  // Comparison count
	int            run_len;    // Settle cycles since last start
	logic [31:0]   rd;         // Read data
	logic [1:0]    rs;         // Response code
	int            busy;       // Activity seen while idle

	// Register rows: address, write data, read-back, response
	typedef struct packed {
		logic [9:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} ssr_row_t;
	ssr_row_t rows [5] = '{
		'{10'h084, 32'hffffffff, 32'h00fff7ff, RESP_OKAY},
		'{10'h0a0, 32'h00a5ab5a, 32'h00a5a35a, RESP_OKAY},
		'{10'h080, 32'h00000001, 32'h00000000, RESP_SLVERR},
		'{10'h0a4, 32'h00000001, 32'h00000000, RESP_SLVERR},
		'{10'h024, 32'hffffffff, 32'h0000ffff, RESP_OKAY}};

	ssr_top dut (
		.clk_sys(clk_sys), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
		.conv_done(conv_done), .conv_start(conv_start), .settling(settling),
		.conv_channel(conv_channel), .conv_setup(conv_setup),
		.conv_filter_type(conv_filter_type), .conv_rate(conv_rate));

	// Clock
	always #5 clk_sys = ~clk_sys;

	// Counts settle cycles; restarts after every start pulse so lost edges cannot hide
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) run_len <= 0;
		else if (conv_start === 1'b1) run_len <= 0;
		else if (settling === 1'b1) run_len <= run_len + 1;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
			n_mismatch++;
		end
	endtask : chk

	// Write with AW and W offered together, each released when taken;
	// no cycle limit in the bus tasks, the watchdog ends a hung transfer
	task axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		req.awaddr  <= a;
		req.wdata   <= d;
		req.wstrb   <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.bready  <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		req.araddr  <= a;
		req.arvalid <= 1'b1;
		req.rready  <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : axi_rd

	// Waits for a start pulse, then checks settle length and active setup
	task wait_start(input int n, input logic [1:0] ch, input logic [2:0] su,
			input logic [3:0] ft, input logic [10:0] rt);
		#1;
		while (conv_start !== 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
		chk(run_len, n, "settle length");
		chk(conv_channel, ch, "channel");
		chk(conv_setup, su, "setup");
		chk({conv_filter_type, conv_rate}, {ft, rt}, "filter and rate");
	endtask : wait_start

	// Converter ends its conversion with a one-cycle conv_done pulse from the next clock edge
	task done();
		@(posedge clk_sys) conv_done <= 1'b1;
		@(posedge clk_sys) conv_done <= 1'b0;
	endtask : done

	task end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// Watchdog: the whole sequence needs well under 50000 cycles
	initial begin
		#500000;
		n_mismatch++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		req = '0;
		conv_done = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		chk({conv_start, settling}, 2'b00, "idle after reset");
		for (int i = 0; i < NUM_SETUP; i++) begin
			axi_rd(10'h084 + 10'(4 * i), rd, rs);
			chk(rd, 32'h00002030, "filter reset");
		end
		foreach (rows[i]) begin
			axi_wr(rows[i].a, rows[i].d, rs);
			chk(rs, rows[i].r, "write response");
			axi_rd(rows[i].a, rd, rs);
			chk(rd, rows[i].e, "read back");
			chk(rs, rows[i].r, "read response");
		end
		// Setup 1: 64-cycle settle, two repeats; setup 3: all zero
		axi_wr(10'h088, 32'h00222030, rs);
		axi_wr(10'h090, 32'h00000000, rs);
		axi_wr(10'h024, 32'h00000b09, rs);
		axi_wr(10'h004, 32'h00000001, rs);
		wait_start(64, 2'd0, 3'd1, 4'h2, 11'h030);
		done();
		wait_start(0, 2'd0, 3'd1, 4'h2, 11'h030);
		done();
		wait_start(0, 2'd0, 3'd1, 4'h2, 11'h030);
		done();
		wait_start(32, 2'd2, 3'd3, 4'h0, 11'h001);
		// Duty-cycled operation set mid-conversion
		axi_wr(10'h004, 32'h00000003, rs);
		done();
		wait_start(64, 2'd0, 3'd1, 4'h2, 11'h030);
		done();
		wait_start(32, 2'd2, 3'd3, 4'h0, 11'h001);
		// Calibration instead, longest settle on setup 3
		axi_wr(10'h004, 32'h00000005, rs);
		axi_wr(10'h090, 32'h00e00000, rs);
		done();
		wait_start(64, 2'd0, 3'd1, 4'h2, 11'h030);
		done();
		wait_start(4096, 2'd2, 3'd3, 4'h0, 11'h001);
		axi_wr(10'h004, 32'h00000000, rs);
		done();
		busy = 0;
		repeat (40) begin
			@(posedge clk_sys);
			#1;
			if (conv_start !== 1'b0 || settling !== 1'b0) busy++;
		end
		chk(busy, 0, "stopped sequencer");
		// Status while stopped: idle, last channel 2, no repeats pending
		axi_rd(10'h028, rd, rs);
		chk(rd, 32'h00000008, "status");
		chk(rs, RESP_OKAY, "status response");
		// Reset in the middle of a settle
		axi_wr(10'h004, 32'h00000001, rs);
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b0;
		#1;
		chk({conv_start, settling}, 2'b00, "reset mid settle");
		chk({rsp.awready, rsp.wready, rsp.arready}, 3'b111, "ready in reset");
		chk({rsp.bvalid, rsp.rvalid}, 2'b00, "no answer in reset");
		@(posedge clk_sys) rstn <= 1'b1;
		axi_rd(10'h088, rd, rs);
		chk(rd, 32'h00002030, "reset value after run");
		end_of_test();
	end

endmodule : testbench
